// ### src/admdc_pkg.sv
package admdc_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int          ADR_W          = 10;
    localparam int          DAT_W          = 32;
    localparam int          IDX_LSB        = 2;

    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam logic [7:0]  IDX_APPLY      = 8'h00;
    localparam logic [7:0]  IDX_ILMODE     = 8'h40;
    localparam logic [7:0]  IDX_DECFIL     = 8'h41;
    localparam logic [7:0]  IDX_BAND       = 8'h42;
    localparam logic [7:0]  IDX_FMT        = 8'h43;
    localparam logic [7:0]  IDX_GAIN       = 8'h44;
    localparam logic [7:0]  IDX_OVR        = 8'h48;
    localparam logic [7:0]  IDX_STAT       = 8'h49;

    // ****************************************
    // field positions
    // ****************************************
    localparam int          APPLY_BIT      = 0;
    localparam int          DEC_SEL_HI_BIT = 5;
    localparam int          DEC_EN_BIT     = 4;
    localparam int          DEC_SEL_LO_MSB = 2;
    localparam int          BAND_MSB       = 2;
    localparam int          FMT_BIT        = 0;
    localparam int          GAIN_MSB       = 6;
    localparam int          OVR_IL         = 0;
    localparam int          OVR_DEC        = 1;
    localparam int          OVR_BAND       = 2;
    localparam int          OVR_FMT        = 3;
    localparam int          OVR_GAIN       = 4;
    localparam int          OVR_W          = 5;
    localparam int          ST_PENDING     = 0;
    localparam int          ST_ARMED       = 1;
    localparam int          ST_IL_RSVD     = 2;
    localparam int          ST_ZONE_BAD    = 3;

    // ****************************************
    // codes
    // ****************************************
    localparam logic [7:0]  IL_MODE_ON     = 8'h00;
    localparam logic [7:0]  IL_MODE_OFF    = 8'h08;
    localparam logic [3:0]  FIL_BP3        = 4'h0;
    localparam logic [3:0]  FIL_BP5        = 4'h4;
    localparam logic [3:0]  FIL_BP1        = 4'h8;
    localparam logic [3:0]  FIL_BP7        = 4'hc;
    localparam logic [3:0]  FIL_LP2        = 4'h2;
    localparam logic [3:0]  FIL_HP2        = 4'h6;
    localparam logic [3:0]  FIL_LPIQ       = 4'h3;
    localparam logic [3:0]  CTR_1          = 4'h1;
    localparam logic [3:0]  CTR_3          = 4'h3;
    localparam logic [3:0]  CTR_5          = 4'h5;
    localparam logic [3:0]  CTR_7          = 4'h7;
    localparam logic [3:0]  CTR_NONE       = 4'h0;
    localparam logic [2:0]  BAND_1ST       = 3'h0;
    localparam logic [2:0]  BAND_2ND       = 3'h1;
    localparam logic [2:0]  BAND_3RD       = 3'h2;
    localparam logic [6:0]  GAIN_UNITY     = 7'h20;
    localparam logic [6:0]  GAIN_MAX       = 7'h7f;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0]  RST_ILMODE     = 8'h00;
    localparam logic [3:0]  RST_DECSEL     = 4'h0;
    localparam logic [2:0]  RST_BAND       = 3'h0;
    localparam logic [6:0]  RST_GAIN       = 7'h00;
    localparam logic [4:0]  RST_OVR        = 5'h00;

    typedef enum logic [1:0] {
        ADMDC_DEC_1X = 2'h0,
        ADMDC_DEC_2X = 2'h1,
        ADMDC_DEC_4X = 2'h2
    } admdc_decim_t;

    typedef enum logic [2:0] {
        ADMDC_FK_NONE     = 3'h0,
        ADMDC_FK_BANDPASS = 3'h1,
        ADMDC_FK_LOWPASS  = 3'h2,
        ADMDC_FK_HIGHPASS = 3'h3,
        ADMDC_FK_LP_IQ    = 3'h4,
        ADMDC_FK_RESERVED = 3'h5
    } admdc_filt_t;

    typedef struct packed {
        logic [7:0]       ilMode;
        logic [3:0]       decSel;
        logic             decEn;
        logic [2:0]       band;
        logic             fmtSel;
        logic [6:0]       gain;
        logic [OVR_W-1:0] ovr;
    } admdc_cfg_t;

endpackage

// ### src/admdc_decode.sv
`timescale 1ns/1ns
module admdc_decode (
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    input  wire logic [7:0]                  ilMode,
    input  wire logic [3:0]                  decSel,
    input  wire logic                        decEn,
    input  wire logic [2:0]                  band,
    input  wire logic                        fmtSel,
    input  wire logic [6:0]                  gain,
    input  wire logic [admdc_pkg::OVR_W-1:0] ovr,
    output logic                             ilEngineEn,
    output logic                             ilReserved,
    output admdc_pkg::admdc_decim_t          decimFactor,
    output admdc_pkg::admdc_filt_t           filterKind,
    output logic [3:0]                       filterCentre,
    output logic                             iqOutput,
    output logic [2:0]                       nyquistZone,
    output logic                             zoneValid,
    output logic                             offsetBinary,
    output logic [6:0]                       gainCode
);

    typedef struct packed {
        logic                    ilEn;
        logic                    ilRsvd;
        admdc_pkg::admdc_decim_t factor;
        admdc_pkg::admdc_filt_t  kind;
        logic [3:0]              centre;
        logic                    iq;
        logic [2:0]              zone;
        logic                    zoneOk;
        logic                    offBin;
        logic [6:0]              gainC;
    } admdc_dec_t;

    admdc_dec_t q;
    admdc_dec_t d;
    logic       selActive;
    logic [3:0] selCode;

    // ****************************************
    // decode of applied settings
    // ****************************************
    always_comb begin
        d = q;
        // reserved engine codes leave the engine on; flagged for software
        d.ilEn = ovr[admdc_pkg::OVR_IL] ? (ilMode != admdc_pkg::IL_MODE_OFF) : 1'b1; // [RULE_01] [RULE_02] [RULE_15]
        d.ilRsvd = ovr[admdc_pkg::OVR_IL] && (ilMode != admdc_pkg::IL_MODE_ON)
                   && (ilMode != admdc_pkg::IL_MODE_OFF); // [RULE_01]
        selActive = ovr[admdc_pkg::OVR_DEC] && decEn; // [RULE_05] [RULE_16]
        selCode = selActive ? decSel : admdc_pkg::FIL_BP3;
        d.iq = 1'b0;
        d.centre = admdc_pkg::CTR_NONE;
        if (!decEn) begin
            d.factor = admdc_pkg::ADMDC_DEC_1X; // [RULE_03]
            d.kind = admdc_pkg::ADMDC_FK_NONE;
        end else begin
            case (selCode)
                admdc_pkg::FIL_BP3: begin
                    d.factor = admdc_pkg::ADMDC_DEC_4X; // [RULE_06]
                    d.kind = admdc_pkg::ADMDC_FK_BANDPASS;
                    d.centre = admdc_pkg::CTR_3;
                end
                admdc_pkg::FIL_BP5: begin
                    d.factor = admdc_pkg::ADMDC_DEC_4X; // [RULE_06]
                    d.kind = admdc_pkg::ADMDC_FK_BANDPASS;
                    d.centre = admdc_pkg::CTR_5;
                end
                admdc_pkg::FIL_BP1: begin
                    d.factor = admdc_pkg::ADMDC_DEC_4X; // [RULE_06]
                    d.kind = admdc_pkg::ADMDC_FK_BANDPASS;
                    d.centre = admdc_pkg::CTR_1;
                end
                admdc_pkg::FIL_BP7: begin
                    d.factor = admdc_pkg::ADMDC_DEC_4X; // [RULE_06]
                    d.kind = admdc_pkg::ADMDC_FK_BANDPASS;
                    d.centre = admdc_pkg::CTR_7;
                end
                admdc_pkg::FIL_LP2: begin
                    d.factor = admdc_pkg::ADMDC_DEC_2X; // [RULE_07]
                    d.kind = admdc_pkg::ADMDC_FK_LOWPASS;
                end
                admdc_pkg::FIL_HP2: begin
                    d.factor = admdc_pkg::ADMDC_DEC_2X; // [RULE_07]
                    d.kind = admdc_pkg::ADMDC_FK_HIGHPASS;
                end
                admdc_pkg::FIL_LPIQ: begin
                    d.factor = admdc_pkg::ADMDC_DEC_4X; // [RULE_07]
                    d.kind = admdc_pkg::ADMDC_FK_LP_IQ;
                    d.iq = 1'b1;
                end
                default: begin
                    // undefined selector: pass full rate rather than guess a filter
                    d.factor = admdc_pkg::ADMDC_DEC_1X;
                    d.kind = admdc_pkg::ADMDC_FK_RESERVED;
                end
            endcase
        end
        d.zone = ovr[admdc_pkg::OVR_BAND] ? band : admdc_pkg::BAND_1ST; // [RULE_09]
        d.zoneOk = (d.zone == admdc_pkg::BAND_1ST) || (d.zone == admdc_pkg::BAND_2ND)
                   || (d.zone == admdc_pkg::BAND_3RD); // [RULE_08]
        d.offBin = ovr[admdc_pkg::OVR_FMT] && fmtSel; // [RULE_10] [RULE_14]
        // gain is code/32, so unity code stands in while not overridden
        d.gainC = ovr[admdc_pkg::OVR_GAIN] ? gain : admdc_pkg::GAIN_UNITY; // [RULE_11] [RULE_12]
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= '{ilEn: 1'b1, ilRsvd: 1'b0, factor: admdc_pkg::ADMDC_DEC_1X, kind: admdc_pkg::ADMDC_FK_NONE,
                   centre: admdc_pkg::CTR_NONE, iq: 1'b0, zone: admdc_pkg::BAND_1ST, zoneOk: 1'b1,
                   offBin: 1'b0, gainC: admdc_pkg::GAIN_UNITY};
        end else begin
            q <= d;
        end
    end

    assign ilEngineEn   = q.ilEn;
    assign ilReserved   = q.ilRsvd;
    assign decimFactor  = q.factor;
    assign filterKind   = q.kind;
    assign filterCentre = q.centre;
    assign iqOutput     = q.iq;
    assign nyquistZone  = q.zone;
    assign zoneValid    = q.zoneOk;
    assign offsetBinary = q.offBin;
    assign gainCode     = q.gainC;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_sel_gated: assert property (decEn && !ovr[admdc_pkg::OVR_DEC] |=> // [RULE_05]
        filterKind == admdc_pkg::ADMDC_FK_BANDPASS && filterCentre == admdc_pkg::CTR_3)
        else $error("selector used without its override");
    a_bandpass_four: assert property (selActive && decSel[1:0] == 2'h0 |=> // [RULE_06]
        decimFactor == admdc_pkg::ADMDC_DEC_4X && filterKind == admdc_pkg::ADMDC_FK_BANDPASS)
        else $error("band-pass code not decimating by four");
    a_lowpass_iq: assert property (selActive && decSel == admdc_pkg::FIL_LPIQ |=> // [RULE_07]
        iqOutput && decimFactor == admdc_pkg::ADMDC_DEC_4X)
        else $error("mixer low-pass not IQ by four");
    a_band_gate: assert property (!ovr[admdc_pkg::OVR_BAND] |=> nyquistZone == admdc_pkg::BAND_1ST) // [RULE_09]
        else $error("band field used without override");
    a_gain_max: assert property (ovr[admdc_pkg::OVR_GAIN] && gain == admdc_pkg::GAIN_MAX |=> // [RULE_11]
        gainCode == admdc_pkg::GAIN_MAX)
        else $error("maximum gain code not passed");

endmodule

// ### src/admdc_regs.sv
`timescale 1ns/1ns
// Behaviour
// [RULE_01] engine mode 0 enables, 8 disables
// [RULE_02] engine mode applies only with override set
// [RULE_03] decimation enable clear gives full rate
// [RULE_04] selector is bit 5 over bits 2-0
// [RULE_05] selector needs override and decimation enable
// [RULE_06] four band-pass codes, each decimating by four
// [RULE_07] low-pass, high-pass by two; mixer IQ by four
// [RULE_08] band codes 000, 001, 010 name zones
// [RULE_09] band field used only with override
// [RULE_10] format bit: 0 twos complement, 1 offset
// [RULE_11] gain is code over 32
// [RULE_12] gain code applies only with override
// [RULE_13] page writes take effect after apply pulse
// [RULE_14] format override clear forces twos complement
// [RULE_15] engine override clear keeps engine enabled
// [RULE_16] decimation override gates selector, resets cleared
module admdc_regs #(
    parameter logic [7:0] IL_MODE_RST = admdc_pkg::RST_ILMODE,
    parameter logic [2:0] BAND_RST    = admdc_pkg::RST_BAND,
    parameter logic [6:0] GAIN_RST    = admdc_pkg::RST_GAIN
) (
    input  wire logic                          clk_sys,
    input  wire logic                          srst,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [admdc_pkg::ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [admdc_pkg::DAT_W-1:0]   wb_dat_i,
    output logic      [admdc_pkg::DAT_W-1:0]   wb_dat_o,
    output logic                               wb_ack_o,
    output logic                               ilEngineEn,
    output admdc_pkg::admdc_decim_t            decimFactor,
    output admdc_pkg::admdc_filt_t             filterKind,
    output logic      [3:0]                    filterCentre,
    output logic                               iqOutput,
    output logic      [2:0]                    nyquistZone,
    output logic                               zoneValid,
    output logic                               offsetBinary,
    output logic      [6:0]                    gainCode
);

    typedef struct packed {
        logic                          ack;
        logic [admdc_pkg::DAT_W-1:0]   rdat;
        logic                          applyBit;
        admdc_pkg::admdc_cfg_t         shadow;
        admdc_pkg::admdc_cfg_t         applied;
    } admdc_state_t;

    localparam admdc_pkg::admdc_cfg_t CFG_RST = '{
        ilMode: IL_MODE_RST,
        decSel: admdc_pkg::RST_DECSEL,
        decEn:  1'b0,
        band:   BAND_RST,
        fmtSel: 1'b0,
        gain:   GAIN_RST,
        ovr:    admdc_pkg::RST_OVR
    };

    admdc_state_t q;
    admdc_state_t d;
    logic [7:0]   idx;
    logic [7:0]   wByte;
    logic         req;
    logic         wrCommit;
    logic         applyFire;
    logic         ilReserved;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [admdc_pkg::DAT_W-1:0] zext8(input logic [7:0] v);
        zext8 = {{(admdc_pkg::DAT_W - 8){1'b0}}, v};
    endfunction

    function automatic logic [7:0] decfilByte(input admdc_pkg::admdc_cfg_t c);
        logic [7:0] b;
        b = 8'h00;
        b[admdc_pkg::DEC_SEL_HI_BIT] = c.decSel[3];
        b[admdc_pkg::DEC_EN_BIT] = c.decEn;
        b[admdc_pkg::DEC_SEL_LO_MSB:0] = c.decSel[2:0];
        decfilByte = b;
    endfunction

    // ****************************************
    // bus slave and register file
    // ****************************************
    always_comb begin
        d = q;
        idx = wb_adr_i[admdc_pkg::ADR_W-1:admdc_pkg::IDX_LSB];
        wByte = wb_dat_i[7:0];
        req = wb_cyc_i && wb_stb_i;
        // ack one cycle after the request, dropped the cycle after
        d.ack = req && !q.ack;
        // writes land at the edge where the master sees ack; only lane 0 holds data
        wrCommit = req && q.ack && wb_we_i && wb_sel_i[0];
        // apply fires on the 1 -> 0 step of the apply bit
        applyFire = wrCommit && (idx == admdc_pkg::IDX_APPLY) && q.applyBit
                    && !wByte[admdc_pkg::APPLY_BIT]; // [RULE_13]
        if (wrCommit) begin
            case (idx)
                admdc_pkg::IDX_APPLY:  d.applyBit = wByte[admdc_pkg::APPLY_BIT];
                admdc_pkg::IDX_ILMODE: d.shadow.ilMode = wByte;
                admdc_pkg::IDX_DECFIL: begin
                    d.shadow.decSel = {wByte[admdc_pkg::DEC_SEL_HI_BIT],
                                       wByte[admdc_pkg::DEC_SEL_LO_MSB:0]}; // [RULE_04]
                    d.shadow.decEn = wByte[admdc_pkg::DEC_EN_BIT]; // [RULE_03]
                end
                admdc_pkg::IDX_BAND:   d.shadow.band = wByte[admdc_pkg::BAND_MSB:0];
                admdc_pkg::IDX_FMT:    d.shadow.fmtSel = wByte[admdc_pkg::FMT_BIT];
                admdc_pkg::IDX_GAIN:   d.shadow.gain = wByte[admdc_pkg::GAIN_MSB:0];
                admdc_pkg::IDX_OVR:    d.shadow.ovr = wByte[admdc_pkg::OVR_W-1:0];
                default: begin
                    // unmapped or read-only: acknowledged, nothing stored
                end
            endcase
        end
        // the decode stage only ever sees the applied copy
        if (applyFire) begin
            d.applied = q.shadow; // [RULE_13]
        end
        d.rdat = '0;
        if (d.ack && !wb_we_i) begin
            case (idx)
                admdc_pkg::IDX_APPLY:  d.rdat[admdc_pkg::APPLY_BIT] = q.applyBit;
                admdc_pkg::IDX_DECFIL: d.rdat = zext8(decfilByte(q.shadow));
                admdc_pkg::IDX_BAND:   d.rdat[admdc_pkg::BAND_MSB:0] = q.shadow.band;
                admdc_pkg::IDX_FMT:    d.rdat[admdc_pkg::FMT_BIT] = q.shadow.fmtSel;
                admdc_pkg::IDX_GAIN:   d.rdat[admdc_pkg::GAIN_MSB:0] = q.shadow.gain;
                admdc_pkg::IDX_OVR:    d.rdat[admdc_pkg::OVR_W-1:0] = q.shadow.ovr;
                admdc_pkg::IDX_STAT: begin
                    d.rdat[admdc_pkg::ST_PENDING] = (q.shadow != q.applied);
                    d.rdat[admdc_pkg::ST_ARMED] = q.applyBit;
                    d.rdat[admdc_pkg::ST_IL_RSVD] = ilReserved;
                    d.rdat[admdc_pkg::ST_ZONE_BAD] = !zoneValid;
                end
                default: d.rdat = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= '{ack: 1'b0, rdat: '0, applyBit: 1'b0, shadow: CFG_RST, applied: CFG_RST};
        end else begin
            q <= d;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;

    // ****************************************
    // decode of applied settings
    // ****************************************
    admdc_decode u_decode (
        .clk_sys      (clk_sys),
        .srst         (srst),
        .ilMode       (q.applied.ilMode),
        .decSel       (q.applied.decSel),
        .decEn        (q.applied.decEn),
        .band         (q.applied.band),
        .fmtSel       (q.applied.fmtSel),
        .gain         (q.applied.gain),
        .ovr          (q.applied.ovr),
        .ilEngineEn   (ilEngineEn),
        .ilReserved   (ilReserved),
        .decimFactor  (decimFactor),
        .filterKind   (filterKind),
        .filterCentre (filterCentre),
        .iqOutput     (iqOutput),
        .nyquistZone  (nyquistZone),
        .zoneValid    (zoneValid),
        .offsetBinary (offsetBinary),
        .gainCode     (gainCode)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence sApplyArm;
        wrCommit && idx == admdc_pkg::IDX_APPLY && wByte[admdc_pkg::APPLY_BIT];
    endsequence
    sequence sApplyDrop;
        wrCommit && idx == admdc_pkg::IDX_APPLY && !wByte[admdc_pkg::APPLY_BIT];
    endsequence

    a_apply_commits: assert property (sApplyArm ##[2:1000] sApplyDrop |=> q.applied == $past(q.shadow)) // [RULE_13]
        else $error("apply pulse did not load settings");
    a_applied_hold: assert property (!applyFire |=> $stable(q.applied)) // [RULE_13]
        else $error("settings changed without apply pulse");
    a_il_default: assert property (!q.applied.ovr[admdc_pkg::OVR_IL] |=> ilEngineEn) // [RULE_15]
        else $error("engine off while override clear");
    a_il_disable: assert property (q.applied.ovr[admdc_pkg::OVR_IL] // [RULE_02]
        && q.applied.ilMode == admdc_pkg::IL_MODE_OFF |=> !ilEngineEn)
        else $error("engine mode 8 did not disable");
    a_full_rate: assert property (!q.applied.decEn |=> decimFactor == admdc_pkg::ADMDC_DEC_1X) // [RULE_03]
        else $error("decimating while disabled");
    a_fmt_default: assert property (!q.applied.ovr[admdc_pkg::OVR_FMT] |=> !offsetBinary) // [RULE_14]
        else $error("offset binary without override");
    a_gain_gate: assert property (q.applied.ovr[admdc_pkg::OVR_GAIN] |=> // [RULE_12]
        gainCode == $past(q.applied.gain))
        else $error("gain code not applied under override");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");

endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    // ****************************************
    // stimulus and design
    // ****************************************
    logic                     clk_sys = 1'b0;
    logic                     srst    = 1'b1;
    logic                     cyc     = 1'b0;
    logic                     stb     = 1'b0;
    logic                     we      = 1'b0;
    logic [9:0]               adr     = 10'h000;
    logic [3:0]               sel     = 4'hf;
    logic [31:0]              dat     = 32'h0;
    logic [31:0]              rdat;
    logic [31:0]              wbDat;
    logic                     wbAck;
    logic                     ilEn, iqOut, zoneOk, offBin;
    admdc_pkg::admdc_decim_t  decim;
    admdc_pkg::admdc_filt_t   kind;
    logic [3:0]               centre;
    logic [2:0]               zone;
    logic [6:0]               gainCode;
    logic [22:0]              hold;
    logic [7:0]               sIl = 8'h00;
    logic [3:0]               sSel = 4'h0;
    logic                     sEn = 1'b0, sFmt = 1'b0;
    logic [2:0]               sBand = 3'h0;
    logic [6:0]               sGain = 7'h00;
    logic [4:0]               sOvr = 5'h00;
    logic [31:0]              r;
    int                       n_fail = 0, compares = 0;
    wire  [22:0]              outs = {ilEn, decim, kind, centre, iqOut, zone, zoneOk, offBin, gainCode};

    admdc_regs dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wbDat), .wb_ack_o(wbAck),
        .ilEngineEn(ilEn), .decimFactor(decim), .filterKind(kind), .filterCentre(centre),
        .iqOutput(iqOut), .nyquistZone(zone), .zoneValid(zoneOk), .offsetBinary(offBin), .gainCode(gainCode));

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    // ****************************************
    // expected effective settings from shadow values
    // ****************************************
    function automatic logic [22:0] calc();
        logic [3:0] c;
        logic [8:0] dkc;
        logic       q;
        logic [2:0] z;
        c   = sOvr[1] ? sSel : 4'h0;
        dkc = 9'h000;
        q   = 1'b0;
        if (sEn) begin
            case (c)
                4'h0: dkc = {2'h2, 3'h1, 4'h3};
                4'h4: dkc = {2'h2, 3'h1, 4'h5};
                4'h8: dkc = {2'h2, 3'h1, 4'h1};
                4'hc: dkc = {2'h2, 3'h1, 4'h7};
                4'h2: dkc = {2'h1, 3'h2, 4'h0};
                4'h6: dkc = {2'h1, 3'h3, 4'h0};
                4'h3: begin
                    dkc = {2'h2, 3'h4, 4'h0};
                    q   = 1'b1;
                end
                default: dkc = {2'h0, 3'h5, 4'h0};
            endcase
        end
        z = sOvr[2] ? sBand : 3'h0;
        return {(!sOvr[0] || sIl != 8'h08), dkc, q, z, (z <= 3'h2), (sOvr[3] & sFmt), (sOvr[4] ? sGain : 7'h20)};
    endfunction

    // ****************************************
    // classic wishbone single cycle
    // ****************************************
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        dat <= d;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (wbAck !== 1'b1 && i < 20);
        q = wbDat;
        if (i >= 20) begin
            n_fail++;
            stop_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic apply();
        bus(1'b1, admdc_pkg::IDX_APPLY, 32'h1, rdat);
        bus(1'b1, admdc_pkg::IDX_APPLY, 32'h0, rdat);
        @(posedge clk_sys);
    endtask

    task automatic stop_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(31988));
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        `CHK(outs, calc())
        for (int i = 0; i < 64; i++) begin
            r     = $urandom;
            // first sixteen walk every selector code under full override
            sIl   = r[0] ? 8'h08 : (r[1] ? 8'h00 : r[15:8]);
            sSel  = (i < 16) ? 4'(i) : r[19:16];
            sEn   = (i < 16) | r[20];
            sBand = r[23:21];
            sFmt  = r[24];
            sGain = (i == 5) ? 7'h7f : r[31:25];
            sOvr  = (i < 16) ? 5'h1f : 5'($urandom);
            hold  = outs;
            bus(1'b1, admdc_pkg::IDX_ILMODE, {24'h0, sIl}, rdat);
            bus(1'b1, admdc_pkg::IDX_DECFIL, 32'({sSel[3], sEn, 1'b0, sSel[2:0]}), rdat);
            bus(1'b1, admdc_pkg::IDX_BAND, {29'h0, sBand}, rdat);
            bus(1'b1, admdc_pkg::IDX_FMT, {31'h0, sFmt}, rdat);
            bus(1'b1, admdc_pkg::IDX_GAIN, {24'h0, 1'b1, sGain}, rdat);
            bus(1'b1, admdc_pkg::IDX_OVR, {27'h0, sOvr}, rdat);
            bus(1'b0, admdc_pkg::IDX_DECFIL, 32'h0, rdat);
            `CHK(rdat, 32'({sSel[3], sEn, 1'b0, sSel[2:0]}))
            bus(1'b0, admdc_pkg::IDX_GAIN, 32'h0, rdat);
            `CHK(rdat, {25'h0, sGain})
            bus(1'b0, admdc_pkg::IDX_ILMODE, 32'h0, rdat);
            `CHK(rdat, 32'h0)
            bus(1'b0, admdc_pkg::IDX_OVR, 32'h0, rdat);
            `CHK(rdat, {27'h0, sOvr})
            `CHK(outs, hold)
            apply();
            `CHK(outs, calc())
            bus(1'b0, admdc_pkg::IDX_STAT, 32'h0, rdat);
            `CHK(rdat, {28'h0, (sOvr[2] && sBand > 3'h2), (sOvr[0] && sIl != 8'h00 && sIl != 8'h08), 2'b00})
        end
        // write with the low byte lane off must be ignored
        sel <= 4'h0;
        bus(1'b1, admdc_pkg::IDX_GAIN, 32'h11, rdat);
        sel <= 4'hf;
        bus(1'b0, admdc_pkg::IDX_GAIN, 32'h0, rdat);
        `CHK(rdat, {25'h0, sGain})
        bus(1'b0, 8'h7f, 32'h0, rdat);
        `CHK(rdat, 32'h0)
        stop_test();
    end
endmodule
